// ==== shared/dmsc_map.svh ====
/*
 * constants of the drive misc/serial configuration bank: parameter indices,
 * reset values, limits and timing counts.
 * assumes a 100 MHz system clock; included by bare name.
 */
`ifndef DMSC_MAP_SVH
`define DMSC_MAP_SVH

// parameter indices within the miscellaneous menu (index 0 is the access key)
`define DMSC_IDX_KEY        5'd0
`define DMSC_IDX_SLOT_LO    5'd1
`define DMSC_IDX_SLOT_HI    5'd10
`define DMSC_IDX_NODE       5'd11
`define DMSC_IDX_RATE       5'd12
`define DMSC_IDX_FUNC       5'd13
`define DMSC_IDX_RSVD       5'd14
`define DMSC_IDX_REV1       5'd15
`define DMSC_IDX_REV2       5'd16
`define DMSC_IDX_LOCK       5'd17
`define DMSC_IDX_VIEW       5'd18
`define DMSC_IDX_VARSEL     5'd19
`define DMSC_IDX_SCALE      5'd20
`define DMSC_IDX_STATUS     5'd21
`define DMSC_IDX_LEDOVR     5'd22
`define DMSC_IDX_HVSEL      5'd23
`define DMSC_IDX_RIDE       5'd24

// reset values and limits
`define DMSC_NODE_RST       7'h01
`define DMSC_NODE_MAX       7'h63
`define DMSC_FUNC_RST       3'h1
`define DMSC_FUNC_MAX       3'h4
`define DMSC_SCALE_RST      11'h3e8
`define DMSC_SEL_MAX        11'h7cf
`define DMSC_LOCK_OPEN      8'h95
`define DMSC_SCALE_UNITY    27'h00003e8

// timing
`define DMSC_CLK_HZ         100000000
`define DMSC_HEALTHY_MS     40
`define DMSC_HEALTHY_CYC    ((`DMSC_CLK_HZ / 1000) * `DMSC_HEALTHY_MS)
`define DMSC_BAUD_LO        4800
`define DMSC_BAUD_HI        9600
`define DMSC_DIV_LO         (`DMSC_CLK_HZ / `DMSC_BAUD_LO)
`define DMSC_DIV_HI         (`DMSC_CLK_HZ / `DMSC_BAUD_HI)

`endif

// ==== shared/dmsc_pkg.sv ====
/*
 * types of the drive misc/serial configuration bank.
 * assumes dmsc_map.svh holds the numbers.
 */
package dmsc_pkg;
	typedef logic [4:0]  dmsc_idx_t;
	typedef logic [15:0] dmsc_word_t;
	typedef enum logic [2:0] {
		DMSC_FN_NONE,
		DMSC_FN_ASCII,
		DMSC_FN_VAR_OUT,
		DMSC_FN_VAR_IN,
		DMSC_FN_WIDE
	} dmsc_func_t;
	typedef enum logic [1:0] {
		DMSC_RT_RUN,
		DMSC_RT_DIP,
		DMSC_RT_WAIT
	} dmsc_ride_t;
endpackage

// ==== tb/dmsc_peer.sv ====
/* far-side serial peer: sinks transmit words, sources received words.
   assumes one clock; it drives its outputs on falling edges. */
`timescale 1ns/100ps
module dmsc_peer (
	input  wire logic        clk_i,      // system clock
	input  wire logic        slow_i,     // stall the transmit sink
	input  wire logic        tx_valid_i, // word offered
	output logic             tx_ready_o, // word taken
	input  wire logic [15:0] tx_data_i,  // offered word
	output logic             rx_valid_o, // word offered
	input  wire logic        rx_ready_i, // word taken
	output logic      [15:0] rx_data_o   // offered word
);
	logic [1:0]  ph = 2'h0;
	logic [15:0] w_q = 16'h0000;
	logic [15:0] last_tx = 16'h0000;
	int          tx_cnt = 0;
	initial rx_valid_o = 1'b0;
	// idle data changes every cycle so a stale word never passes for a fresh one
	assign rx_data_o  = rx_valid_o ? w_q : {8{ph}};
	assign tx_ready_o = !slow_i || (ph == 2'h3);
	always @(negedge clk_i) ph <= ph + 2'h1;
	// record each transmitted word
	always @(posedge clk_i) begin
		if (tx_valid_i && tx_ready_o) begin
			last_tx <= tx_data_i;
			tx_cnt  <= tx_cnt + 1;
		end
	end
	// offer a word and hold it until the edge that takes it
	task automatic send(input logic [15:0] w);
		@(negedge clk_i);
		w_q = w;
		rx_valid_o = 1'b1;
		do @(posedge clk_i); while (rx_ready_i !== 1'b1);
		@(negedge clk_i);
		rx_valid_o = 1'b0;
	endtask
endmodule

// ==== tb/tb.sv ====
/* self-checking bench of the misc/serial configuration bank.
   assumes a 100 MHz clock and a healthy interval shortened to 20 cycles. */
`timescale 1ns/100ps
`include "dmsc_map.svh"
module tb;
	import dmsc_pkg::*;
	localparam int HC = 20;
	logic clk_sys_i = 0, srst_i = 1, drv_reset_i = 0, par_wr_i = 0, par_rd_i = 0;
	logic mains_ok_i = 1, run_i = 0, enable_i = 0, third_tick_i = 0, wb_ready_i = 1, slow = 1;
	dmsc_idx_t   par_idx_i = '0;
	dmsc_word_t  par_wdata_i = '0, par_rdata_o;
	logic [7:0]  status_i = 8'h5a, led_norm_i = 8'h0f, led_o;
	logic [15:0] sel_val_i = 16'h00c8, wide_out_i = 16'h3039, tx_data_o, rx_data_i;
	logic [15:0] wb_data_o, wide_in_o, baud_div_o;
	logic [39:0] wide_ascii_o;
	logic [10:0] view_sel_o, wb_sel_o;
	logic [6:0]  node_addr_o;
	dmsc_func_t  port_func_o;
	logic par_rvalid_o, store_req_o, locked_o, hv_board_o, sense_mode_o, fire_dis_o, blank_o;
	logic self_reset_o, restart_o, tx_valid_o, tx_ready_i, rx_valid_i, rx_ready_o, wb_valid_o;
	int error_cnt = 0, comparisons = 0, wb_cnt = 0, i, c0;
	dmsc_top #(.HEALTHY_CYC(HC)) dut_u (.*);
	dmsc_peer peer_u (.clk_i(clk_sys_i), .slow_i(slow), .tx_valid_i(tx_valid_o),
		.tx_ready_o(tx_ready_i), .tx_data_i(tx_data_o), .rx_valid_o(rx_valid_i),
		.rx_ready_i(rx_ready_o), .rx_data_o(rx_data_i));
	always #5 clk_sys_i = ~clk_sys_i;
	// count write-back handshakes
	always @(posedge clk_sys_i) if (wb_valid_o && wb_ready_i) wb_cnt <= wb_cnt + 1;
	task chk(input string n, input logic [39:0] seen, input logic [39:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task step(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	task wr(input dmsc_idx_t x, input dmsc_word_t d);
		@(negedge clk_sys_i);
		par_wr_i = 1;
		par_idx_i = x;
		par_wdata_i = d;
		@(negedge clk_sys_i);
		par_wr_i = 0;
	endtask
	// read strobe for one edge, answer checked while it stands
	task rdc(input dmsc_idx_t x, input dmsc_word_t e);
		@(negedge clk_sys_i);
		par_rd_i = 1;
		par_idx_i = x;
		@(negedge clk_sys_i);
		par_rd_i = 0;
		chk("read answer", par_rvalid_o, 1);
		chk($sformatf("param %0d", x), par_rdata_o, e);
	endtask
	task pulse;
		@(negedge clk_sys_i);
		drv_reset_i = 1;
		@(negedge clk_sys_i);
		drv_reset_i = 0;
		step(2);
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// watchdog: the tests need well under 2000 cycles
	initial begin
		#200000;
		error_cnt++;
		tally_and_finish;
	end
	initial begin
		step(6);
		srst_i = 0;
		chk("baud", baud_div_o, 20833);
		chk("func", port_func_o, 1);
		rdc(`DMSC_IDX_NODE, 1);
		rdc(`DMSC_IDX_SCALE, 1000);
		rdc(`DMSC_IDX_VIEW, 0);
		wr(`DMSC_IDX_NODE, 100);
		rdc(`DMSC_IDX_NODE, 99);
		wr(`DMSC_IDX_RATE, 1);
		step(2);
		chk("baud", baud_div_o, 20833);
		pulse;
		chk("baud", baud_div_o, 10416);
		wr(`DMSC_IDX_REV1, 16'h0123);
		rdc(`DMSC_IDX_REV1, 0);
		$display("test settings done");
		rdc(`DMSC_IDX_STATUS, 16'h005a);
		chk("leds", led_o, 8'h0f);
		wr(`DMSC_IDX_LEDOVR, 1);
		wr(`DMSC_IDX_STATUS, 16'h00a5);
		step(2);
		chk("leds", led_o, 8'ha5);
		rdc(`DMSC_IDX_STATUS, 16'h00a5);
		wr(`DMSC_IDX_LOCK, 5);
		pulse;
		chk("locked", locked_o, 1);
		wr(`DMSC_IDX_NODE, 7);
		rdc(`DMSC_IDX_NODE, 99);
		wr(`DMSC_IDX_KEY, 5);
		step(1);
		chk("locked", locked_o, 0);
		wr(`DMSC_IDX_LOCK, 0);
		pulse;
		wr(`DMSC_IDX_NODE, 7);
		rdc(`DMSC_IDX_NODE, 7);
		wr(`DMSC_IDX_VIEW, 16'd2500);
		wr(`DMSC_IDX_HVSEL, 1);
		step(1);
		chk("node out", node_addr_o, 7);
		chk("view", view_sel_o, 1999);
		chk("hv board", hv_board_o, 1);
		wr(`DMSC_IDX_LOCK, 149);
		wr(`DMSC_IDX_KEY, 1);
		chk("store", store_req_o, 1);
		pulse;
		chk("locked", locked_o, 0);
		$display("test status and lock done");
		wr(`DMSC_IDX_FUNC, 0);
		rdc(`DMSC_IDX_FUNC, 1);
		wr(`DMSC_IDX_FUNC, 2);
		pulse;
		c0 = peer_u.tx_cnt;
		step(12);
		chk("tx var", peer_u.last_tx, 16'h00c8);
		chk("tx stream", (peer_u.tx_cnt - c0) >= 2, 1);
		wr(`DMSC_IDX_SCALE, 500);
		wr(`DMSC_IDX_VARSEL, 7);
		wr(`DMSC_IDX_FUNC, 3);
		pulse;
		chk("func", port_func_o, 3);
		wb_ready_i = 0;
		for (i = 0; i < 9; i++) peer_u.send(16'd2000);
		chk("rx ready", rx_ready_o, 0);
		chk("wb valid", wb_valid_o, 1);
		chk("wb data", wb_data_o, 1000);
		chk("wb sel", wb_sel_o, 7);
		wb_ready_i = 1;
		step(20);
		chk("wb count", wb_cnt, 9);
		wr(`DMSC_IDX_SCALE, 1000);
		peer_u.send(16'd1234);
		step(3);
		chk("wb unity", wb_data_o, 1234);
		wr(`DMSC_IDX_FUNC, 4);
		pulse;
		c0 = peer_u.tx_cnt;
		@(negedge clk_sys_i) third_tick_i = 1;
		@(negedge clk_sys_i) third_tick_i = 0;
		step(20);
		chk("tx word", peer_u.last_tx, 16'h3039);
		chk("tx count", peer_u.tx_cnt - c0, 1);
		peer_u.send(16'd1234);
		step(3);
		chk("wide in", wide_in_o, 1234);
		chk("ascii", wide_ascii_o, "01234");
		$display("test port functions done");
		wr(`DMSC_IDX_RIDE, 1);
		step(1);
		chk("sense", sense_mode_o, 1);
		run_i = 1;
		enable_i = 1;
		mains_ok_i = 0;
		step(5);
		chk("fire off", fire_dis_o, 1);
		chk("blank", blank_o, 1);
		mains_ok_i = 1;
		step(HC / 2);
		mains_ok_i = 0;
		step(1);
		mains_ok_i = 1;
		step(HC - 2);
		chk("fire off", fire_dis_o, 1);
		for (i = 0; i < 20 && self_reset_o !== 1'b1; i++) @(posedge clk_sys_i) #1;
		chk("self reset", self_reset_o, 1);
		chk("restart", restart_o, 1);
		chk("fire off", fire_dis_o, 0);
		$display("test ride-through done");
		tally_and_finish;
	end
endmodule

// ==== verilog/dmsc_top.sv ====
/*
 * drive miscellaneous/serial configuration bank with its receive fifo.
 * assumes all inputs synchronous to clk_sys_i except mains_ok_i, a raw
 * comparator level; the parameter port is driven by the keypad/serial core.
 */
`timescale 1ns/100ps
`include "dmsc_map.svh"

// receive buffer: flop storage, honest full/empty
module dmsc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_sys_i, // system clock
	input  wire logic             srst_i,    // sync reset
	input  wire logic             in_valid_i,// push request
	output logic                  in_ready_o,// not full
	input  wire logic [WIDTH-1:0] in_data_i, // push data
	output logic                  out_valid_o,// not empty
	input  wire logic             out_ready_i,// pop request
	output logic      [WIDTH-1:0] out_data_o // head data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wp_r;
	logic [AW-1:0]    rp_r;
	logic [AW:0]      cnt_r;
	logic [AW:0]      cnt_nxt;
	wire              push = in_valid_i && in_ready_o;
	wire              pop  = out_valid_o && out_ready_i;

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
	end

	assign cnt_nxt     = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	assign out_valid_o = (cnt_r != '0);
	assign out_data_o  = mem_r[rp_r];

	// pointers and occupancy
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
			in_ready_o <= 1'b1;
		end else begin
			if (push) wp_r <= wp_r + 1'b1;
			if (pop) rp_r <= rp_r + 1'b1;
			cnt_r <= cnt_nxt;
			// ready kept in a flop so the pin never sees decode glitches
			in_ready_o <= (cnt_nxt != DEPTH[AW:0]);
		end
	end

	// storage has no reset; only written slots are ever read
	always_ff @(posedge clk_sys_i) begin
		if (push) mem_r[wp_r] <= in_data_i;
	end
endmodule

module dmsc_top #(
	parameter int          HEALTHY_CYC = `DMSC_HEALTHY_CYC, // healthy interval in cycles
	parameter int          FIFO_DEPTH  = 8,                 // receive buffer depth
	parameter logic [9:0]  REV_PRIMARY = 10'h000,           // revision value, at most 1000
	parameter logic [9:0]  REV_SECOND  = 10'h000            // revision value, at most 1000
) (
	input  wire logic              clk_sys_i,     // system clock
	input  wire logic              srst_i,        // sync reset
	input  wire logic              drv_reset_i,   // drive reset pulse
	input  wire logic              par_wr_i,      // parameter write strobe
	input  wire logic              par_rd_i,      // parameter read strobe
	input  wire dmsc_pkg::dmsc_idx_t  par_idx_i,  // parameter index
	input  wire dmsc_pkg::dmsc_word_t par_wdata_i,// write value
	output dmsc_pkg::dmsc_word_t   par_rdata_o,   // read value
	output logic                   par_rvalid_o,  // read answer pulse
	output logic                   store_req_o,   // key 1 written: store pending
	output logic                   locked_o,      // access restricted
	output logic [15:0]            baud_div_o,    // active bit period in cycles
	output dmsc_pkg::dmsc_func_t   port_func_o,   // active port function
	output logic [6:0]             node_addr_o,   // multidrop address
	output logic [10:0]            view_sel_o,    // power-on keypad view
	output logic                   hv_board_o,    // 660V board fitted
	output logic                   sense_mode_o,  // analogue input 2 is mains sense
	input  wire logic              mains_ok_i,    // raw mains-healthy comparator
	input  wire logic              run_i,         // run command
	input  wire logic              enable_i,      // enable command
	output logic                   fire_dis_o,    // thyristor firing disabled
	output logic                   blank_o,       // display blanked
	output logic                   self_reset_o,  // ride-through reset pulse
	output logic                   restart_o,     // restart permitted pulse
	input  wire logic [7:0]        status_i,      // live drive status bits
	input  wire logic [7:0]        led_norm_i,    // normal led pattern
	output logic [7:0]             led_o,         // keypad leds except ready
	input  wire logic              third_tick_i,  // pulse at 3x mains freq
	input  wire logic [15:0]       sel_val_i,     // value of selected parameter
	input  wire logic [15:0]       wide_out_i,    // wide outgoing integer
	output logic                   tx_valid_o,    // transmit word valid
	input  wire logic              tx_ready_i,    // transmitter accepts
	output logic [15:0]            tx_data_o,     // transmit word
	input  wire logic              rx_valid_i,    // received word valid
	output logic                   rx_ready_o,    // receive buffer not full
	input  wire logic [15:0]       rx_data_i,     // received word
	output logic                   wb_valid_o,    // parameter write-back valid
	input  wire logic              wb_ready_i,    // write-back accepted
	output logic [10:0]            wb_sel_o,      // write-back target
	output logic [15:0]            wb_data_o,     // scaled write-back value
	output logic [15:0]            wide_in_o,     // wide incoming integer
	output logic [39:0]            wide_ascii_o   // five ascii digits, msd first
);
	import dmsc_pkg::*;

	initial begin
		if (HEALTHY_CYC < 1) $error("healthy interval must be at least one cycle");
		if (REV_PRIMARY > 10'd1000 || REV_SECOND > 10'd1000) $error("revision above 1000");
	end

	logic [10:0] slot_r [10];
	logic [6:0]  node_r;
	logic        rate_r, rate_act_r;
	logic [2:0]  func_r, func_act_r;
	logic [7:0]  rsvd_r, lock_r, stat_wr_r;
	logic [10:0] view_r, varsel_r, scale_r;
	logic        ledovr_r, hv_r, ride_r, locked_r;
	logic        ok_s1_r, ok_s2_r;
	dmsc_ride_t  rt_r;
	logic [31:0] hcnt_r;
	logic [15:0] wide_in_r;

	// decode: a locked bank takes only the key
	wire idx_slot  = (par_idx_i >= `DMSC_IDX_SLOT_LO) && (par_idx_i <= `DMSC_IDX_SLOT_HI);
	wire key_wr    = par_wr_i && (par_idx_i == `DMSC_IDX_KEY);
	wire wr_ok     = par_wr_i && !locked_r;
	wire [3:0] slot_ix = 4'(par_idx_i - `DMSC_IDX_SLOT_LO);
	wire [10:0] wsel   = (par_wdata_i > 16'(`DMSC_SEL_MAX)) ? `DMSC_SEL_MAX
	                     : par_wdata_i[10:0];                      // whole word compared
	wire [6:0] node_wv = (par_wdata_i > 16'(`DMSC_NODE_MAX)) ? `DMSC_NODE_MAX
	                     : par_wdata_i[6:0];
	wire func_legal = (par_wdata_i >= 16'd1) && (par_wdata_i <= 16'(`DMSC_FUNC_MAX));
	wire lock_armed = (lock_r != 8'h00) && (lock_r != `DMSC_LOCK_OPEN);
	wire [7:0] stat_word = ledovr_r ? stat_wr_r : status_i;
	function automatic logic wr_at(input logic [4:0] ix);
		wr_at = wr_ok && (par_idx_i == ix);
	endfunction

	// menu slots; out-of-range selector writes clamp to 1999
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			for (int i = 0; i < 10; i++) slot_r[i] <= 11'h000;
		end else if (wr_ok && idx_slot) begin
			slot_r[slot_ix] <= wsel;
		end
	end

	// stored settings
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			node_r   <= `DMSC_NODE_RST;
			rate_r   <= 1'b0;
			func_r   <= `DMSC_FUNC_RST;
			rsvd_r   <= 8'h00;
			lock_r   <= 8'h00;
			view_r   <= 11'h000;
			varsel_r <= 11'h000;
			scale_r  <= `DMSC_SCALE_RST;
			ledovr_r <= 1'b0;
			hv_r     <= 1'b0;
			ride_r   <= 1'b0;
			stat_wr_r <= 8'h00;
		end else begin
			if (wr_at(`DMSC_IDX_NODE)) node_r <= node_wv;
			if (wr_at(`DMSC_IDX_RATE)) rate_r <= par_wdata_i[0];
			if (wr_at(`DMSC_IDX_FUNC) && func_legal) func_r <= par_wdata_i[2:0];
			if (wr_at(`DMSC_IDX_RSVD)) rsvd_r <= par_wdata_i[7:0];
			if (wr_at(`DMSC_IDX_LOCK)) lock_r <= par_wdata_i[7:0];
			if (wr_at(`DMSC_IDX_VIEW)) view_r <= wsel;
			if (wr_at(`DMSC_IDX_VARSEL)) varsel_r <= wsel;
			if (wr_at(`DMSC_IDX_SCALE)) scale_r <= wsel;
			if (wr_at(`DMSC_IDX_LEDOVR)) ledovr_r <= par_wdata_i[0];
			if (wr_at(`DMSC_IDX_HVSEL)) hv_r <= par_wdata_i[0];
			if (wr_at(`DMSC_IDX_RIDE)) ride_r <= par_wdata_i[0];
			// status becomes writable only under led override
			if (wr_at(`DMSC_IDX_STATUS) && ledovr_r) stat_wr_r <= par_wdata_i[7:0];
		end
	end

	// reset-effective copies and lock state; the key write wins over relock
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			rate_act_r <= 1'b0;
			func_act_r <= `DMSC_FUNC_RST;
			locked_r   <= 1'b0;
		end else begin
			if (drv_reset_i || self_reset_o) begin
				rate_act_r <= rate_r;
				func_act_r <= func_r;
				locked_r   <= lock_armed;
			end
			if (key_wr && (par_wdata_i[7:0] == lock_r) && (par_wdata_i[15:8] == 8'h00))
				locked_r <= 1'b0;
		end
	end

	// read mux: narrow values sit in the low bits
	dmsc_word_t rd_mux;
	always_comb begin
		rd_mux = 16'h0000;
		case (par_idx_i)
			`DMSC_IDX_NODE:   rd_mux = {9'h000, node_r};
			`DMSC_IDX_RATE:   rd_mux = {15'h0000, rate_r};
			`DMSC_IDX_FUNC:   rd_mux = {13'h0000, func_r};
			`DMSC_IDX_RSVD:   rd_mux = {8'h00, rsvd_r};
			`DMSC_IDX_REV1:   rd_mux = {6'h00, REV_PRIMARY};
			`DMSC_IDX_REV2:   rd_mux = {6'h00, REV_SECOND};
			`DMSC_IDX_LOCK:   rd_mux = {8'h00, lock_r};
			`DMSC_IDX_VIEW:   rd_mux = {5'h00, view_r};
			`DMSC_IDX_VARSEL: rd_mux = {5'h00, varsel_r};
			`DMSC_IDX_SCALE:  rd_mux = {5'h00, scale_r};
			`DMSC_IDX_STATUS: rd_mux = {8'h00, stat_word};
			`DMSC_IDX_LEDOVR: rd_mux = {15'h0000, ledovr_r};
			`DMSC_IDX_HVSEL:  rd_mux = {15'h0000, hv_r};
			`DMSC_IDX_RIDE:   rd_mux = {15'h0000, ride_r};
			default:          rd_mux = idx_slot ? {5'h00, slot_r[slot_ix]} : 16'h0000;
		endcase
	end

	// registered read answer, one cycle after the strobe
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			par_rdata_o  <= 16'h0000;
			par_rvalid_o <= 1'b0;
			store_req_o  <= 1'b0;
		end else begin
			par_rvalid_o <= par_rd_i;
			if (par_rd_i) par_rdata_o <= rd_mux;
			store_req_o  <= key_wr && (par_wdata_i == 16'h0001);
		end
	end

	// configuration outputs
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			baud_div_o   <= 16'(`DMSC_DIV_LO);
			port_func_o  <= DMSC_FN_ASCII;
			node_addr_o  <= `DMSC_NODE_RST;
			view_sel_o   <= 11'h000;
			hv_board_o   <= 1'b0;
			sense_mode_o <= 1'b0;
			led_o        <= 8'h00;
			locked_o     <= 1'b0;
		end else begin
			baud_div_o   <= rate_act_r ? 16'(`DMSC_DIV_HI) : 16'(`DMSC_DIV_LO);
			port_func_o  <= dmsc_func_t'(func_act_r);
			node_addr_o  <= node_r;
			view_sel_o   <= view_r;
			hv_board_o   <= hv_r;
			sense_mode_o <= ride_r;
			led_o        <= ledovr_r ? stat_wr_r : led_norm_i;
			locked_o     <= locked_r;
		end
	end

	// mains flag synchroniser
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			ok_s1_r <= 1'b1;
			ok_s2_r <= 1'b1;
		end else begin
			ok_s1_r <= mains_ok_i;
			ok_s2_r <= ok_s1_r;
		end
	end

	// ride-through: a dip always wins over the healthy count
	dmsc_ride_t rt_nxt;
	wire dip      = ride_r && !ok_s2_r;
	wire hdone    = (hcnt_r == 32'(HEALTHY_CYC - 1));
	always_comb begin
		rt_nxt = rt_r;
		case (rt_r)
			DMSC_RT_RUN:  rt_nxt = dip ? DMSC_RT_DIP : DMSC_RT_RUN;
			DMSC_RT_DIP:  rt_nxt = ok_s2_r ? DMSC_RT_WAIT : DMSC_RT_DIP;
			DMSC_RT_WAIT: rt_nxt = !ok_s2_r ? DMSC_RT_DIP : (hdone ? DMSC_RT_RUN : DMSC_RT_WAIT);
			default:      rt_nxt = DMSC_RT_RUN;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			rt_r         <= DMSC_RT_RUN;
			hcnt_r       <= 32'h0;
			fire_dis_o   <= 1'b0;
			blank_o      <= 1'b0;
			self_reset_o <= 1'b0;
			restart_o    <= 1'b0;
		end else begin
			rt_r   <= rt_nxt;
			hcnt_r <= (rt_r == DMSC_RT_WAIT && ok_s2_r) ? hcnt_r + 32'h1 : 32'h0;
			fire_dis_o   <= (rt_nxt != DMSC_RT_RUN);
			blank_o      <= (rt_nxt != DMSC_RT_RUN);
			self_reset_o <= (rt_r == DMSC_RT_WAIT) && ok_s2_r && hdone;
			restart_o    <= (rt_r == DMSC_RT_WAIT) && ok_s2_r && hdone && run_i && enable_i;
		end
	end

	// receive path through the buffer; drained per function
	wire        rxq_valid;
	wire [15:0] rxq_data;
	wire        fn_in   = (port_func_o == DMSC_FN_VAR_IN);
	wire        fn_wide = (port_func_o == DMSC_FN_WIDE);
	wire        wb_free = !wb_valid_o || wb_ready_i;
	wire        rxq_pop = rxq_valid && ((fn_in && wb_free) || fn_wide || !(fn_in || fn_wide));
	wire [26:0] scaled  = 27'(rxq_data) * 27'(scale_r) / `DMSC_SCALE_UNITY;

	dmsc_fifo #(
		.WIDTH (16),
		.DEPTH (FIFO_DEPTH)
	) u_rxq (
		.clk_sys_i   (clk_sys_i),
		.srst_i      (srst_i),
		.in_valid_i  (rx_valid_i),
		.in_ready_o  (rx_ready_o),
		.in_data_i   (rx_data_i),
		.out_valid_o (rxq_valid),
		.out_ready_i (rxq_pop),
		.out_data_o  (rxq_data)
	);

	// parameter write-back (function 3) and wide incoming (function 4)
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			wb_valid_o <= 1'b0;
			wb_sel_o   <= 11'h000;
			wb_data_o  <= 16'h0000;
			wide_in_r  <= 16'h0000;
		end else begin
			if (wb_valid_o && wb_ready_i) wb_valid_o <= 1'b0;
			if (rxq_pop && fn_in) begin
				wb_valid_o <= 1'b1;
				wb_sel_o   <= varsel_r;
				wb_data_o  <= (scaled > 27'h000ffff) ? 16'hffff : scaled[15:0];
			end
			if (rxq_pop && fn_wide) wide_in_r <= rxq_data;
		end
	end

	// five unsigned ascii digits of the wide incoming value
	function automatic logic [7:0] dig(input logic [15:0] v, input logic [15:0] p);
		logic [15:0] q;
		q = (v / p) % 16'd10;
		dig = 8'h30 + q[7:0];
	endfunction

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			wide_in_o    <= 16'h0000;
			wide_ascii_o <= {5{8'h30}};
		end else begin
			wide_in_o    <= wide_in_r;
			wide_ascii_o <= {dig(wide_in_r, 16'd10000), dig(wide_in_r, 16'd1000),
			                 dig(wide_in_r, 16'd100), dig(wide_in_r, 16'd10),
			                 dig(wide_in_r, 16'd1)};
		end
	end

	// transmit: function 2 streams continuously, function 4 on each third-cycle tick
	wire tx_free = !tx_valid_o || tx_ready_i;
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			tx_valid_o <= 1'b0;
			tx_data_o  <= 16'h0000;
		end else if (tx_free) begin
			tx_valid_o <= 1'b0;
			if (port_func_o == DMSC_FN_VAR_OUT) begin
				tx_valid_o <= 1'b1;
				tx_data_o  <= sel_val_i;
			end else if (fn_wide && third_tick_i) begin
				tx_valid_o <= 1'b1;
				tx_data_o  <= wide_out_i;
			end
		end
	end

	// checks
	a_node_clamp: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		wr_ok && par_idx_i == `DMSC_IDX_NODE && par_wdata_i >= 16'd100 |=> node_r == 7'd99)
		else $error("node address not clamped to 99");
	a_rate_held: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		!drv_reset_i && !self_reset_o |=> $stable(rate_act_r))
		else $error("line rate changed without reset");
	a_rate_copy: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		drv_reset_i |=> rate_act_r == $past(rate_r) ##1 baud_div_o ==
		(rate_act_r ? 16'(`DMSC_DIV_HI) : 16'(`DMSC_DIV_LO)))
		else $error("reset did not load line rate");
	a_func_range: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		func_r >= 3'd1 && func_r <= 3'd4)
		else $error("port function out of range");
	a_lock_block: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		locked_r && par_wr_i && par_idx_i == `DMSC_IDX_NODE |=> $stable(node_r))
		else $error("write accepted while locked");
	a_dip_fire: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		ride_r && !ok_s2_r |=> fire_dis_o && blank_o)
		else $error("dip did not stop firing");
	a_restart_gate: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		restart_o |-> self_reset_o && $past(run_i) && $past(enable_i))
		else $error("restart without run and enable");
	a_led_map: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		ledovr_r |=> led_o == $past(stat_wr_r))
		else $error("leds do not show status word");
	a_wide_store: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		rxq_pop && fn_wide |=> wide_in_r == $past(rxq_data) ##1 wide_in_o == $past(wide_in_r))
		else $error("wide incoming not stored");
	a_scale_wb: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		rxq_pop && fn_in && scale_r == 11'd1000 |=> wb_valid_o && wb_data_o == $past(rxq_data))
		else $error("unity scale changed data");
	c_ride_cycle: cover property (@(posedge clk_sys_i) disable iff (srst_i)
		fire_dis_o ##[1:1000] self_reset_o);
	c_rx_full: cover property (@(posedge clk_sys_i) disable iff (srst_i) !rx_ready_o);
	c_unlock: cover property (@(posedge clk_sys_i) disable iff (srst_i)
		locked_r ##1 !locked_r);
	c_tick_tx: cover property (@(posedge clk_sys_i) disable iff (srst_i)
		fn_wide && third_tick_i ##1 tx_valid_o);
endmodule
